// ---- hdl/sync_indirect_access.v ----
`timescale 1ns/1ns
`include "sync_indirect_defs.vh"


module sync_indirect_access #(
    parameter RESET_CYCLES = `RESET_CYCLES
) (
    // Clock and bus initialise
    input wire i_clk,
    input wire i_resetn,
    // Host word bus
    input wire [3:0] i_addr,
    input wire i_sel,
    input wire i_wr,
    input wire i_rd,
    input wire i_word,
    input wire [15:0] i_wdata,
    output reg [15:0] o_rdata,
    output reg o_ack,
    output reg o_err,
    // Device side
    input wire [7:0] i_change_flags,
    input wire [7:0] i_modem_rx,
    output wire o_full_reset,
    output reg o_tx_marking,
    output reg o_rx_enable,
    output reg o_cfg_load,
    output reg [7:0] o_protocol,
    output reg [15:0] o_reg_flat_sel
);

// ----------------------------------------
// Registers and nets
// ----------------------------------------
reg [3:0] ptr;
reg [15:0] cache;
reg reload;
wire busy;
wire done;
wire hit_ctrl;
wire hit_data;
wire wr_ctrl;
wire wr_data;
wire start;
wire [3:0] next_ptr;
wire [15:0] wr_onehot;
wire [255:0] ind_flat;
wire clear_err;
genvar g;

// One-hot masks of the TX error entry that full reset clears, of the RX error entry whose low byte it clears and of the modem entry with its live receive byte
localparam [15:0] SEL_RX_ERR = 16'h0001 << `IND_RX_ERROR;
localparam [15:0] SEL_TX_ERR = 16'h0001 << `IND_TX_ERROR;
localparam [15:0] SEL_MODEM = 16'h0001 << `IND_MODEM;

// ----------------------------------------
// Address decode
// ----------------------------------------
// word-only decode of control word
assign hit_ctrl = i_sel && i_word && (i_addr == `OFF_SELECT_RESET);
assign hit_data = i_sel && i_word && (i_addr == `OFF_DATA_WINDOW);
assign wr_ctrl = hit_ctrl && i_wr;
assign wr_data = hit_data && i_wr;
assign start = wr_ctrl && i_wdata[`RESET_BIT];
// Pointer wraps from 15 back to 0
// pointer steps on data write
assign next_ptr = wr_ctrl ? i_wdata[`PTR_MSB:`PTR_LSB] :
                  wr_data ? ptr + 4'h1 : ptr;

// ----------------------------------------
// Full reset sequencer
// ----------------------------------------
full_reset_seq #(
    .CYCLES(RESET_CYCLES)
) u_seq (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(start),
    .o_busy(busy),
    .o_done(done)
);

// Bit 7 and the reset output both show the sequencer busy flag
assign o_full_reset = busy;

// ----------------------------------------
// Pointer
// ----------------------------------------
always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        ptr <= 4'h0;
        reload <= 1'b0;
    end else begin
        ptr <= next_ptr;
        reload <= wr_ctrl || wr_data;
    end
end

// ----------------------------------------
// Indirect register file
// ----------------------------------------
// Writes land at the pointer before it steps
assign wr_onehot = wr_data ? (16'h0001 << ptr) : 16'h0000;
// error bytes cleared as reset starts
assign clear_err = start && !busy;

generate
    for (g = 0; g < 16; g = g + 1) begin : g_ind
        reg [15:0] word;
        assign ind_flat[g*16 +: 16] = word;
        always @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                word <= `ZERO16;
            end else if (clear_err && SEL_TX_ERR[g]) begin
                word <= `ZERO16;
            end else if (clear_err && SEL_RX_ERR[g]) begin
                word <= word & `RX_ERR_MASK;
            end else if (SEL_MODEM[g]) begin
                // receive byte is read-only and live
                if (wr_onehot[g]) begin
                    word[15:8] <= i_wdata[15:8];
                end
                word[7:0] <= i_modem_rx;
            end else if (wr_onehot[g]) begin
                word <= i_wdata;
            end
        end
    end
endgenerate

// ----------------------------------------
// Read cache
// ----------------------------------------
// Loads one edge after the pointer settles
always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        cache <= `ZERO16;
    end else if (reload) begin
        cache <= ind_flat[{ptr, 4'h0} +: 16];
    end
end

// ----------------------------------------
// Bus answers
// ----------------------------------------
always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        o_rdata <= `ZERO16;
        o_ack <= 1'b0;
        o_err <= 1'b0;
    end else begin
        // Byte and unmapped accesses answer with an error pulse
        o_ack <= i_sel && (i_rd || i_wr) && (hit_ctrl || hit_data);
        o_err <= i_sel && (i_rd || i_wr) && !(hit_ctrl || hit_data);
        if (hit_ctrl && i_rd) begin
            o_rdata <= {i_change_flags, busy, 3'b000, ptr};
        end else if (hit_data && i_rd) begin
            o_rdata <= cache;
        end else begin
            o_rdata <= `ZERO16;
        end
    end
end

// ----------------------------------------
// Interface state during full reset
// ----------------------------------------
always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        o_tx_marking <= 1'b1;
        o_rx_enable <= 1'b0;
        o_cfg_load <= 1'b0;
        o_protocol <= 8'h00;
        o_reg_flat_sel <= `ZERO16;
    end else begin
        o_cfg_load <= 1'b0;
        o_reg_flat_sel <= 16'h0001 << ptr;
        if (busy) begin
            o_tx_marking <= 1'b1;
            o_rx_enable <= 1'b0;
        end
        if (done) begin
            o_protocol <= ind_flat[{`IND_PROTOCOL, 4'h0} +: 8];
            o_cfg_load <= 1'b1;
        end else if (wr_data && ptr == `IND_PROTOCOL) begin
            o_tx_marking <= o_tx_marking;
        end
    end
end

endmodule

// ---- hdl/sync_indirect_defs.vh ----
`ifndef SYNC_INDIRECT_DEFS_VH
`define SYNC_INDIRECT_DEFS_VH

// Register word offsets (byte addresses on the host bus)
`define OFF_SELECT_RESET 4'h8
`define OFF_DATA_WINDOW 4'hA

// Control register fields
`define PTR_MSB 3
`define PTR_LSB 0
`define RESET_BIT 7
`define CTRL_UNUSED_MASK 8'h70

// Indirect register indices
`define IND_PROTOCOL 4'h0
`define IND_RX_ERROR 4'h1
`define IND_TX_ERROR 4'h2
`define IND_MODEM 4'h4

// Reset values
`define ZERO16 16'h0000
`define RX_ERR_MASK 16'hFF00

// Full reset sequence length in ns, and in cycles at 125 MHz
`define RESET_TIME_NS 200
`define CLK_PERIOD_NS 8
`define RESET_CYCLES ((`RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- hdl/full_reset_seq.v ----
`timescale 1ns/1ns
`include "sync_indirect_defs.vh"

module full_reset_seq #(
    parameter CYCLES = `RESET_CYCLES
) (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Control
    input wire i_start,
    // Status
    output wire o_busy,
    output reg o_done
);

reg [15:0] count;
reg busy;

assign o_busy = busy;

always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        count <= 16'h0000;
        busy <= 1'b0;
        o_done <= 1'b0;
    end else begin
        o_done <= 1'b0;
        if (!busy) begin
            if (i_start) begin
                busy <= 1'b1;
                count <= CYCLES[15:0] - 16'h0001;
            end
        end else if (count == 16'h0000) begin
            busy <= 1'b0;
            o_done <= 1'b1;
        end else begin
            count <= count - 16'h0001;
        end
    end
end

endmodule

// ---- tb/sync_indirect_access_chk.sv ----
`timescale 1ns/1ns
module sync_indirect_access_chk #(parameter RESET_CYCLES = 6) (
    input wire i_clk, i_resetn, i_sel, i_wr, i_rd, i_word,
    input wire [3:0] i_addr,
    input wire [15:0] i_wdata, o_rdata, o_reg_flat_sel,
    input wire [7:0] i_change_flags,
    input wire o_ack, o_err, o_full_reset, o_tx_marking, o_rx_enable,
    input wire o_cfg_load
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    wire tk = i_sel & (i_wr | i_rd);
    wire ok = tk & i_word & (i_addr == 4'h8 | i_addr == 4'hA);
    wire cw = ok & i_wr & (i_addr == 4'h8) & !o_full_reset;
    wire cr = ok & i_rd & (i_addr == 4'h8);
    wire dw = ok & i_wr & (i_addr == 4'hA) & !o_full_reset;
    wire [3:0] wp = i_wdata[3:0];
    wire [15:0] rot = {o_reg_flat_sel[14:0], o_reg_flat_sel[15]};
    int n;
    // Cycles spent in full reset so far
    always @(posedge i_clk or negedge i_resetn)
        n <= !i_resetn ? 0 : (o_full_reset ? n + 1 : 0);
    AST_ACK: assert property (ok |=> o_ack && !o_err)
        else $error("ack missing");
    AST_ERR: assert property (tk && !ok |=> o_err && !o_ack)
        else $error("refusal missing");
    AST_FLAGS: assert property
        (cr |=> o_rdata[15:8] == $past(i_change_flags))
        else $error("flag byte wrong");
    AST_UNUSED: assert property (cr |=> o_rdata[6:4] == 3'h0)
        else $error("unused bits set");
    AST_PTR: assert property
        (cw |-> ##2 o_reg_flat_sel == 16'h1 << $past(wp, 2))
        else $error("pointer wrong");
    AST_INC: assert property
        (dw |-> ##2 o_reg_flat_sel == $past(rot))
        else $error("no increment");
    AST_GO: assert property (cw && i_wdata[7] |=> o_full_reset)
        else $error("reset not started");
    AST_LEN: assert property ($fell(o_full_reset) |-> n == RESET_CYCLES)
        else $error("reset length wrong");
    AST_BIT7: assert property (cr && o_full_reset |=> o_rdata[7])
        else $error("bit 7 low in reset");
    AST_QUIET: assert property (o_full_reset |-> o_tx_marking && !o_rx_enable)
        else $error("line not quiet");
    AST_CFG: assert property ($fell(o_full_reset) |=> o_cfg_load)
        else $error("config load missing");
endmodule
bind sync_indirect_access sync_indirect_access_chk
    #(.RESET_CYCLES(RESET_CYCLES)) chk_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_sel(i_sel), .i_wr(i_wr),
    .i_rd(i_rd), .i_word(i_word), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_reg_flat_sel(o_reg_flat_sel),
    .i_change_flags(i_change_flags), .o_ack(o_ack), .o_err(o_err),
    .o_full_reset(o_full_reset), .o_tx_marking(o_tx_marking),
    .o_rx_enable(o_rx_enable), .o_cfg_load(o_cfg_load));

// ---- tb/host_model.sv ----
`timescale 1ns/1ns
module host_model (
    input wire i_clk, i_ack, i_err,
    input wire [15:0] i_rdata,
    output logic o_sel = 0, o_wr = 0, o_rd = 0, o_word = 0,
    output logic [3:0] o_addr = 4'h0,
    output logic [15:0] o_wdata = 16'h0000
);
    logic [15:0] q;
    logic [1:0] r;
    // One access, then released lines scrambled
    task xfer(input logic w, wd, input logic [3:0] a, input logic [15:0] d);
        @(negedge i_clk);
        {o_sel, o_wr, o_rd, o_word, o_addr, o_wdata} = {1'b1, w, !w, wd, a, d};
        @(negedge i_clk);
        q = i_rdata;
        r = {i_err, i_ack};
        {o_sel, o_wr, o_rd, o_addr, o_wdata} = {3'b000, ~a, ~d};
    endtask
endmodule

// ---- tb/sync_indirect_access_tb.sv ----
`timescale 1ns/1ns
module sync_indirect_access_tb;
    logic i_clk = 0, i_resetn = 0;
    logic [7:0] i_change_flags = 8'h00, i_modem_rx = 8'h00;
    wire i_sel, i_wr, i_rd, i_word, o_ack, o_err, o_full_reset;
    wire o_tx_marking, o_rx_enable, o_cfg_load;
    wire [3:0] i_addr;
    wire [7:0] o_protocol;
    wire [15:0] i_wdata, o_rdata, o_reg_flat_sel;
    integer miscompares = 0, checks_done = 0, cyc = 0, seed = 32'hc7ea_ab66;
    integer m [16];
    always #4 i_clk = !i_clk;
    host_model host_u (.i_clk(i_clk), .i_ack(o_ack), .i_err(o_err),
        .i_rdata(o_rdata), .o_sel(i_sel), .o_wr(i_wr), .o_rd(i_rd),
        .o_word(i_word), .o_addr(i_addr), .o_wdata(i_wdata));
    sync_indirect_access #(.RESET_CYCLES(6)) dut_u (.*);
    task cmp(input logic [15:0] g, e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function logic [15:0] ex(input integer i);
        ex = (i == 4) ? {m[4][15:8], i_modem_rx} : m[i][15:0];
    endfunction
    // Point at each register, read twice from the cache
    task rd_all;
        for (int i = 0; i < 16; i++) begin
            host_u.xfer(1, 1, 4'h8, 16'(i));
            repeat (2) @(negedge i_clk);
            host_u.xfer(0, 1, 4'hA, 16'h0000);
            cmp(host_u.q, ex(i));
            host_u.xfer(0, 1, 4'hA, 16'h0000);
            cmp(host_u.q, ex(i));
        end
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    initial begin
        i_change_flags = $random(seed);
        i_modem_rx = $random(seed);
        repeat (16) @(negedge i_clk);
        i_resetn = 1;
        host_u.xfer(1, 1, 4'h8, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            m[i] = $random(seed);
            host_u.xfer(1, 1, 4'hA, m[i][15:0]);
        end
        rd_all;
        host_u.xfer(1, 1, 4'h8, 16'h0075);
        host_u.xfer(0, 1, 4'h8, 16'h0000);
        cmp(host_u.q, {i_change_flags, 8'h05});
        cmp(o_reg_flat_sel, 16'h0020);
        host_u.xfer(1, 1, 4'h8, 16'h000F);
        m[15] = $random(seed);
        host_u.xfer(1, 1, 4'hA, m[15][15:0]);
        repeat (2) @(negedge i_clk);
        host_u.xfer(0, 1, 4'hA, 16'h0000);
        cmp(host_u.q, ex(0));
        host_u.xfer(1, 0, 4'hA, 16'hFFFF);
        cmp({14'h0, host_u.r}, 16'h0002);
        host_u.xfer(0, 1, 4'h2, 16'h0000);
        cmp({14'h0, host_u.r}, 16'h0002);
        host_u.xfer(1, 1, 4'h8, 16'h0085);
        host_u.xfer(1, 1, 4'h8, 16'h0085);
        host_u.xfer(0, 1, 4'h8, 16'h0000);
        cmp(host_u.q, {i_change_flags, 8'h85});
        for (int k = 0; k < 20 && o_full_reset !== 1'b0; k++) @(negedge i_clk);
        cmp({15'h0, o_full_reset}, 16'h0000);
        @(negedge i_clk);
        cmp({8'h00, o_protocol}, {8'h00, m[0][7:0]});
        cmp({15'h0, o_cfg_load}, 16'h0001);
        m[2] = 0;
        m[1] = m[1] & 32'h0000_FF00;
        rd_all;
        // Bus initialise in mid-run clears every entry but the live modem receive byte
        i_modem_rx = $random(seed);
        i_resetn = 0;
        repeat (2) @(negedge i_clk);
        i_resetn = 1;
        for (int i = 0; i < 16; i++) m[i] = 0;
        rd_all;
        tally_and_finish;
    end
endmodule
